//--- ascr_regs.sv
/*
  Alert status, channel sequence and configuration register bank.
  Assumes the I2C engine presents decoded register requests on link_clk and
  holds each until taken; the comparator datapath raises alert events and
  conversion phase levels on ref_clk.
*/
// Summary of operation
// [R1] Three 8-bit alert status registers record alerts
// [R2] Writing FF clears that whole alert register
// [R3] Writing one clears only that alert bit
// [R4] Config D2:D1 both one clears all alerts
// [R5] After that clear pin becomes alert output
// [R6] Inputs register: even bits low, odd high
// [R7] Current register: sense alerts, overrange, D7:D6 reserved
// [R8] Temperature register: remote, internal, overtemp, open diode
// [R9] Channel select picks autocycle channels, D7:D6 reserved
// [R10] Sixteen-bit configuration register at 0x09
// [R11] Upper byte: diff, pseudo, autocycle, delay enables
// [R12] Delaying and pseudo-differential pair enabled at reset
// [R13] Writing one disables the matching delay function
// [R14] Defer during bus activity; abort past 1 us
// [R15] Bit-trial deferral makes conversion time variable
// [R16] D3 enables 50 ns glitch filter, default on
// [R17] Host should avoid traffic during conversions
// [R18] D2:D1 select none, busy, alert or reset
// [R19] Reset code reads back as 1,0
// [R20] Alert bits stay set until cleared
// [R21] Summary flag set while any alert set
`timescale 1ns/1ns
module ascr_regs (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  input  wire logic              link_clk,
  input  wire logic              link_rst_b,
  input  wire logic              link_req_valid,
  input  wire ascr_pkg::ascr_req_t link_req,
  output logic                   link_req_busy,
  output logic                   link_rd_valid,
  output logic [15:0]            link_rd_data,
  input  wire logic              i2c_bus_active,
  input  wire ascr_pkg::ascr_alert_t alert_event,
  input  wire logic              conv_busy,
  input  wire logic              bit_trial_pending,
  output logic [7:0]             chan_select,
  output ascr_pkg::ascr_cfg_t    cfg_fields,
  output logic                   alert_flag,
  output logic                   alert_busy_pin,
  output logic                   defer_sample,
  output logic                   defer_bit_trial,
  output logic                   conv_abort
);

  //////////////////////////////////////////////////////////////////////////
  // Link side: capture one request, toggle it across, wait for the ack
  ascr_pkg::ascr_req_t hold;
  logic                req_tgl;
  logic                ack_s1;
  logic                ack_s2;
  logic                ack_s3;
  logic                ack_tgl;
  logic [15:0]         rd_word;
  wire                 ack_edge = ack_s2 ^ ack_s3;
  wire                 take_req = link_req_valid & ~link_req_busy;

  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      hold          <= '0;
      req_tgl       <= 1'b0;
      link_req_busy <= 1'b0;
      ack_s1        <= 1'b0;
      ack_s2        <= 1'b0;
      ack_s3        <= 1'b0;
      link_rd_valid <= 1'b0;
      link_rd_data  <= 16'h0000;
    end else begin
      ack_s1        <= ack_tgl;
      ack_s2        <= ack_s1;
      ack_s3        <= ack_s2;
      link_rd_valid <= link_req_busy & ack_edge & ~hold.write;
      if (take_req) begin
        hold          <= link_req;
        req_tgl       <= ~req_tgl;
        link_req_busy <= 1'b1;
      end else if (link_req_busy && ack_edge) begin
        link_req_busy <= 1'b0;
        // Core holds rd_word until the next request, so it is stable here
        link_rd_data  <= hold.write ? link_rd_data : rd_word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Core side synchronisers
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic bus_s1;
  logic bus_s2;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      bus_s1 <= 1'b0;
      bus_s2 <= 1'b0;
    end else if (clk_en) begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      bus_s1 <= i2c_bus_active;
      bus_s2 <= bus_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Request decode
  wire req_edge  = req_s2 ^ req_s3;
  wire do_write  = req_edge & hold.write;
  wire wr_chan   = do_write & (hold.addr == ascr_pkg::OFF_CHAN_SELECT);
  wire wr_cfg    = do_write & (hold.addr == ascr_pkg::OFF_OP_CONFIG);
  wire [1:0] wr_pin_mode =
    hold.data[ascr_pkg::CFG_PIN_MODE_HI:ascr_pkg::CFG_PIN_MODE_LO];
  wire clear_all = wr_cfg & (wr_pin_mode == ascr_pkg::PIN_RESET); // [R4] [R18]

  //////////////////////////////////////////////////////////////////////////
  // Alert status registers, one per group
  logic [7:0] alert_reg [3];
  wire  [7:0] alert_set [3];
  wire  [7:0] alert_next [3];
  wire  [7:0] alert_mask [3];
  wire  [7:0] alert_off [3];

  // [R6] [R7] [R8] Event bit positions match the register bit positions
  assign alert_set[0]  = alert_event.inputs;
  assign alert_set[1]  = alert_event.current;
  assign alert_set[2]  = alert_event.temperature;
  assign alert_mask[0] = ascr_pkg::MASK_ALERT_INPUTS;
  assign alert_mask[1] = ascr_pkg::MASK_ALERT_CURRENT; // [R7]
  assign alert_mask[2] = ascr_pkg::MASK_ALERT_TEMP;
  assign alert_off[0]  = ascr_pkg::OFF_ALERT_INPUTS;
  assign alert_off[1]  = ascr_pkg::OFF_ALERT_CURRENT;
  assign alert_off[2]  = ascr_pkg::OFF_ALERT_TEMP;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_alert
      wire       wr_hit = do_write & (hold.addr == alert_off[g]);
      // FF clears all bits through the same path as single-bit clears
      wire [7:0] clr    = wr_hit ? hold.data[7:0] : 8'h00; // [R2] [R3]
      // A new event in the clearing cycle survives the clear
      assign alert_next[g] = clear_all ? (alert_set[g] & alert_mask[g])
        : ((alert_reg[g] & ~clr) | alert_set[g]) & alert_mask[g]; // [R20]

      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          alert_reg[g] <= ascr_pkg::RST_ALERT;
        end else if (clk_en) begin
          alert_reg[g] <= alert_next[g]; // [R1]
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Channel select and configuration
  logic [15:0] op_config;
  wire  [15:0] cfg_wr_val = hold.data & ascr_pkg::MASK_OP_CONFIG;
  // Reset code is stored as alert mode so the pin keeps reporting alerts
  wire  [15:0] cfg_next = clear_all
    ? {cfg_wr_val[15:3], ascr_pkg::PIN_ALERT, cfg_wr_val[0]} // [R5] [R19]
    : cfg_wr_val;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      chan_select <= ascr_pkg::RST_CHAN_SELECT;
      op_config   <= ascr_pkg::RST_OP_CONFIG; // [R12] [R16]
    end else if (clk_en) begin
      if (wr_chan) begin
        chan_select <= hold.data[7:0] & ascr_pkg::MASK_CHAN_SELECT; // [R9]
      end
      if (wr_cfg) begin
        op_config <= cfg_next; // [R10]
      end
    end
  end

  // [R11] Upper-byte and lower-byte fields straight from the register
  assign cfg_fields.range_2x     = op_config[ascr_pkg::CFG_RANGE_LO +: 4];
  assign cfg_fields.diff_en      = op_config[ascr_pkg::CFG_DIFF_LO +: 2];
  assign cfg_fields.pseudo_en    = op_config[ascr_pkg::CFG_PSEUDO_LO +: 2];
  assign cfg_fields.autocycle_en = op_config[ascr_pkg::CFG_AUTOCYCLE];
  assign cfg_fields.filter_en    = op_config[ascr_pkg::CFG_FILTER_EN]; // [R16]

  //////////////////////////////////////////////////////////////////////////
  // Readback word, captured at the request and held for the link
  logic [15:0] rd_mux;
  always_comb begin
    unique case (hold.addr)
      ascr_pkg::OFF_ALERT_INPUTS:  rd_mux = {8'h00, alert_reg[0]};
      ascr_pkg::OFF_ALERT_CURRENT: rd_mux = {8'h00, alert_reg[1]};
      ascr_pkg::OFF_ALERT_TEMP:    rd_mux = {8'h00, alert_reg[2]};
      ascr_pkg::OFF_CHAN_SELECT:   rd_mux = {8'h00, chan_select};
      ascr_pkg::OFF_OP_CONFIG:     rd_mux = op_config;
      default:                     rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_word <= 16'h0000;
      ack_tgl <= 1'b0;
    end else if (clk_en && req_edge) begin
      rd_word <= rd_mux;
      ack_tgl <= ~ack_tgl;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Alert flag and alert/busy pin
  wire [1:0] pin_mode =
    op_config[ascr_pkg::CFG_PIN_MODE_HI:ascr_pkg::CFG_PIN_MODE_LO];
  wire any_alert = |{alert_next[0], alert_next[1], alert_next[2]}; // [R21]
  wire pin_pol   = op_config[ascr_pkg::CFG_PIN_POL];
  logic pin_active;
  always_comb begin
    unique case (pin_mode) // [R18]
      ascr_pkg::PIN_NONE:  pin_active = 1'b0;
      ascr_pkg::PIN_BUSY:  pin_active = conv_busy;
      ascr_pkg::PIN_ALERT: pin_active = any_alert;
      ascr_pkg::PIN_RESET: pin_active = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Noise-aware deferral; enable bits are active when zero
  wire sm_delay_on = ~op_config[ascr_pkg::CFG_SM_DELAY_DIS]; // [R13]
  wire bt_delay_on = ~op_config[ascr_pkg::CFG_BT_DELAY_DIS]; // [R13]
  wire bt_hold     = bt_delay_on & bus_s2 & bit_trial_pending; // [R15]
  logic [ascr_pkg::BT_CNT_W-1:0] bt_cnt;
  localparam logic [ascr_pkg::BT_CNT_W-1:0] BT_LIMIT =
    ascr_pkg::BT_CNT_W'(ascr_pkg::BT_LIMIT_CYC);
  wire bt_over = bt_hold & (bt_cnt == BT_LIMIT);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      bt_cnt          <= '0;
      conv_abort      <= 1'b0;
      defer_sample    <= 1'b0;
      defer_bit_trial <= 1'b0;
      alert_flag      <= 1'b0;
      // Mode none with D0 low idles at the inactive high level
      alert_busy_pin  <= 1'b1;
    end else if (clk_en) begin
      // Count accumulates over one pending bit trial, cleared when it ends or on abort
      if (!bit_trial_pending || bt_over) begin
        bt_cnt <= '0;
      end else if (bt_hold) begin
        bt_cnt <= bt_cnt + 1'b1; // [R14]
      end
      conv_abort      <= bt_over; // [R14]
      defer_sample    <= sm_delay_on & bus_s2; // [R14]
      defer_bit_trial <= bt_delay_on & bus_s2; // [R14]
      alert_flag      <= any_alert; // [R21]
      // Polarity bit high means active-high pin
      alert_busy_pin  <= pin_active ~^ pin_pol;
    end
  end

endmodule : ascr_regs

//--- ascr_pkg.sv
/*
  Package for the alert status and configuration register bank: register
  offsets, field positions, reset values, timing constants and the structs
  that carry requests, alert events and configuration fields.
  Assumes one core clock at 100 MHz and an I2C engine on its own clock.
*/
package ascr_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFF_ALERT_INPUTS  = 8'h05;
  localparam logic [7:0] OFF_ALERT_CURRENT = 8'h06;
  localparam logic [7:0] OFF_ALERT_TEMP    = 8'h07;
  localparam logic [7:0] OFF_CHAN_SELECT   = 8'h08;
  localparam logic [7:0] OFF_OP_CONFIG     = 8'h09;

  //////////////////////////////////////////////////////////////////////////
  // Reset values and implemented-bit masks
  localparam logic [7:0]  RST_ALERT       = 8'h00;
  localparam logic [7:0]  RST_CHAN_SELECT = 8'h00;
  localparam logic [15:0] RST_OP_CONFIG   = 16'h0808;
  localparam logic [7:0]  MASK_ALERT_INPUTS  = 8'hFF;
  localparam logic [7:0]  MASK_ALERT_CURRENT = 8'h3F;
  localparam logic [7:0]  MASK_ALERT_TEMP    = 8'hFF;
  localparam logic [7:0]  MASK_CHAN_SELECT   = 8'h3F;
  localparam logic [15:0] MASK_OP_CONFIG     = 16'h7FFF;
  localparam logic [7:0]  CLEAR_ALL_CODE     = 8'hFF;

  //////////////////////////////////////////////////////////////////////////
  // Configuration field positions
  localparam int CFG_PIN_POL      = 0;
  localparam int CFG_PIN_MODE_LO  = 1;
  localparam int CFG_PIN_MODE_HI  = 2;
  localparam int CFG_FILTER_EN    = 3;
  localparam int CFG_RANGE_LO     = 4;
  localparam int CFG_DIFF_LO      = 8;
  localparam int CFG_PSEUDO_LO    = 10;
  localparam int CFG_AUTOCYCLE    = 12;
  localparam int CFG_BT_DELAY_DIS = 13;
  localparam int CFG_SM_DELAY_DIS = 14;

  // Pin function codes held in D2:D1
  localparam logic [1:0] PIN_NONE  = 2'h0;
  localparam logic [1:0] PIN_BUSY  = 2'h1;
  localparam logic [1:0] PIN_ALERT = 2'h2;
  localparam logic [1:0] PIN_RESET = 2'h3;

  //////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int BT_LIMIT_NS     = 1000;
  localparam int BT_LIMIT_CYC    = BT_LIMIT_NS / CLK_PERIOD_NS;
  localparam int GLITCH_REJ_NS   = 50;
  localparam int BT_CNT_W        = 8;

  //////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        write;
    logic [7:0]  addr;
    logic [15:0] data;
  } ascr_req_t;

  typedef struct packed {
    logic [7:0] temperature;
    logic [7:0] current;
    logic [7:0] inputs;
  } ascr_alert_t;

  typedef struct packed {
    logic [3:0] range_2x;
    logic [1:0] diff_en;
    logic [1:0] pseudo_en;
    logic       autocycle_en;
    logic       filter_en;
  } ascr_cfg_t;

endpackage : ascr_pkg

//--- ascr_regs_chk.sv
/* Port assertions for the alert and configuration register bank.
   Assumes clk_en stays high while a link request is in flight. */
`timescale 1ns/1ns
module ascr_regs_chk (
  input wire logic                  ref_clk,
  input wire logic                  rst_b,
  input wire logic                  clk_en,
  input wire logic                  link_clk,
  input wire logic                  link_rst_b,
  input wire logic                  link_req_busy,
  input wire logic                  link_rd_valid,
  input wire logic                  i2c_bus_active,
  input wire ascr_pkg::ascr_alert_t alert_event,
  input wire logic                  bit_trial_pending,
  input wire logic [7:0]            chan_select,
  input wire ascr_pkg::ascr_cfg_t   cfg_fields,
  input wire logic                  alert_flag,
  input wire logic                  defer_sample,
  input wire logic                  defer_bit_trial,
  input wire logic                  conv_abort
);
  ////////////////////////////////////////////////////////////////////////////
  // Sync stages plus the output register fit in four quiet cycles
  sequence s_quiet;
    (clk_en && !i2c_bus_active) [*4];
  endsequence
  AST_FLAG_SET: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && (|{alert_event.temperature, alert_event.inputs,
      alert_event.current & ascr_pkg::MASK_ALERT_CURRENT}) |=> alert_flag)
    else $error("Flag missed event");
  AST_FLAG_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    alert_flag && clk_en && !link_req_busy |=> alert_flag)
    else $error("Alert flag dropped without a clear");
  AST_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_quiet |-> !defer_sample && !defer_bit_trial)
    else $error("Deferral while bus idle");
  AST_ABORT_ONE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    conv_abort && clk_en |=> !conv_abort) else $error("Abort not a pulse");
  AST_ABORT_CAUSE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(conv_abort) |-> $past(bit_trial_pending))
    else $error("Abort without bit trial");
  AST_RESET: assert property (@(posedge ref_clk) !rst_b |=>
    !alert_flag && chan_select == 8'h00 && cfg_fields == 10'h009)
    else $error("Reset values wrong");
  AST_RDV: assert property (@(posedge link_clk) disable iff (!link_rst_b)
    link_rd_valid |-> $past(link_req_busy) && !link_req_busy ##1 !link_rd_valid)
    else $error("Read valid misplaced");
  AST_ANSWER: assert property (@(posedge link_clk) disable iff (!link_rst_b)
    $rose(link_req_busy) |-> ##[1:40] !link_req_busy)
    else $error("Request never answered");
endmodule : ascr_regs_chk

bind ascr_regs ascr_regs_chk u_ascr_regs_chk (.ref_clk, .rst_b, .clk_en,
  .link_clk, .link_rst_b, .link_req_busy, .link_rd_valid, .i2c_bus_active,
  .alert_event, .bit_trial_pending, .chan_select, .cfg_fields, .alert_flag,
  .defer_sample, .defer_bit_trial, .conv_abort);

//--- ascr_host.sv
/* Host model: issues one register request at a time on the link.
   Assumes busy and read-valid answer on link_clk. */
`timescale 1ns/1ns
module ascr_host (
  input  wire logic           link_clk,
  input  wire logic           link_req_busy,
  input  wire logic           link_rd_valid,
  input  wire logic [15:0]    link_rd_data,
  output logic                link_req_valid,
  output ascr_pkg::ascr_req_t link_req
);
  initial begin
    link_req_valid = 1'b0;
    link_req = '0;
  end
  // Waits for each answer, so no overlapping traffic
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [15:0] d, output logic [15:0] rd, output logic ok);
    int n;
    @(posedge link_clk);
    #1 link_req_valid = 1'b1;
    link_req = {w, a, d};
    for (n = 0; n < 30 && link_req_busy !== 1'b1; n++) begin
      @(posedge link_clk);
      #1;
    end
    ok = link_req_busy === 1'b1;
    link_req_valid = 1'b0;
    link_req = ~link_req;  // Stale lines would hide a late sample
    for (n = 0; n < 30 && link_req_busy !== 1'b0; n++) begin
      @(posedge link_clk);
      #1;
    end
    ok = ok && link_req_busy === 1'b0 && (w || link_rd_valid === 1'b1);
    rd = link_rd_data;
  endtask : xfer
endmodule : ascr_host

//--- test_ascr_regs.sv
/* Bench for the register bank: clocks, host model, reference model.
   Assumes the package, checker and host model are compiled first. */
`timescale 1ns/1ns
module test_ascr_regs;
  logic ref_clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
  logic i2c_bus_active = 1'b0, conv_busy = 1'b0, bit_trial_pending = 1'b0;
  ascr_pkg::ascr_alert_t alert_event = '0;
  ascr_pkg::ascr_req_t   link_req;
  ascr_pkg::ascr_cfg_t   cfg_fields;
  logic        link_req_valid, link_req_busy, link_rd_valid, ok;
  logic        alert_flag, alert_busy_pin, conv_abort, defer_sample;
  logic        defer_bit_trial;
  logic [15:0] link_rd_data, cfg, r;
  logic [7:0]  chan_select, chn;
  logic [7:0]  alr [3];
  logic [31:0] v;
  int          err_count = 0, n_tests = 0, i, n;
  always #5 ref_clk = ~ref_clk;
  always #6 link_clk = ~link_clk;
  ascr_regs u_ascr_regs (.ref_clk, .rst_b, .clk_en, .link_clk,
    .link_rst_b(rst_b), .link_req_valid, .link_req, .link_req_busy,
    .link_rd_valid, .link_rd_data, .i2c_bus_active, .alert_event,
    .conv_busy, .bit_trial_pending, .chan_select, .cfg_fields, .alert_flag,
    .alert_busy_pin, .defer_sample, .defer_bit_trial, .conv_abort);
  ascr_host u_ascr_host (.link_clk, .link_req_busy, .link_rd_valid,
    .link_rd_data, .link_req_valid, .link_req);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0, got}, {15'h0, exp});
  endtask : chk1
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    u_ascr_host.xfer(w, a, d, r, ok);
    if (ok !== 1'b1) begin
      err_count++;
      final_report();
    end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
    if (a >= 8'h05 && a <= 8'h07) alr[a - 8'h05] &= ~d[7:0];
    if (a == 8'h08) chn = d[7:0] & ascr_pkg::MASK_CHAN_SELECT;
    if (a == 8'h09) cfg = d & ascr_pkg::MASK_OP_CONFIG;
    if (a == 8'h09 && d[2:1] == 2'h3) begin
      alr = '{default: 8'h00};
      cfg[1] = 1'b0;
    end
  endtask : wr
  function automatic logic [15:0] exp_rd(input logic [7:0] a);
    if (a >= 8'h05 && a <= 8'h07) return {8'h00, alr[a - 8'h05]};
    if (a == 8'h08) return {8'h00, chn};
    return (a == 8'h09) ? cfg : 16'h0000;
  endfunction : exp_rd
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 16'h0000);
    chk16(r, exp_rd(a));
  endtask : rd
  task automatic raise(input logic [23:0] e);
    @(posedge ref_clk);
    #1 alert_event = e;
    @(posedge ref_clk);
    #1 alert_event = '0;
    alr[0] |= e[7:0];
    alr[1] |= e[15:8] & ascr_pkg::MASK_ALERT_CURRENT;
    alr[2] |= e[23:16];
    repeat (2) @(posedge ref_clk);
    #1 chk1(alert_flag, |{alr[0], alr[1], alr[2]});
  endtask : raise
  function automatic logic pin_exp;
    logic act;
    act = (cfg[2:1] == ascr_pkg::PIN_BUSY && conv_busy) ||
      (cfg[2:1] == ascr_pkg::PIN_ALERT && |{alr[0], alr[1], alr[2]});
    return act ~^ cfg[0];
  endfunction : pin_exp
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    final_report();
  end
  initial begin
    v = $urandom(32'hF512D45F);
    alr = '{default: 8'h00};
    chn = ascr_pkg::RST_CHAN_SELECT;
    cfg = ascr_pkg::RST_OP_CONFIG;
    repeat (12) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    for (i = 5; i < 11; i++) rd(i[7:0]);
    v = $urandom;
    wr(8'h08, v[15:0]);
    rd(8'h08);
    chk16({8'h00, chan_select}, {8'h00, chn});
    $display("test reset and channel select done");
    for (i = 0; i < 3; i++) begin
      v = $urandom;
      raise(v[23:0]);
      n = i + 5;
      v = 32'h1 << ($urandom % 8);
      wr(n[7:0], v[15:0]);
      rd(n[7:0]);
    end
    wr(8'h05, {8'h00, ascr_pkg::CLEAR_ALL_CODE});
    rd(8'h05);
    $display("test alert clear done");
    for (i = 0; i < 4; i++) begin
      v = $urandom;
      raise(v[23:0]);
      conv_busy = v[24];
      wr(8'h09, {2'h0, v[13:3], i[1:0], v[31]});
      rd(8'h09);
      repeat (3) @(posedge ref_clk);
      #1 chk1(alert_busy_pin, pin_exp());
      chk1(alert_flag, |{alr[0], alr[1], alr[2]});
      chk16({6'h00, cfg_fields}, {6'h00, cfg[7:4], cfg[9:8], cfg[11:10],
        cfg[12], cfg[3]});
    end
    raise(24'h000001);
    chk1(alert_busy_pin, pin_exp());
    $display("test pin modes done");
    wr(8'h09, cfg & 16'h9FFF);
    for (i = 0; i < 2; i++) begin
      i2c_bus_active = 1'b1;
      bit_trial_pending = 1'b1;
      n = 0;
      repeat (150) begin
        @(posedge ref_clk);
        #1 n += (conv_abort === 1'b1);
      end
      chk1(defer_sample, i == 0);
      chk1(defer_bit_trial, i == 0);
      chk16(n[15:0], (i == 0) ? 16'h0001 : 16'h0000);
      bit_trial_pending = 1'b0;
      i2c_bus_active = 1'b0;
      wr(8'h09, cfg | 16'h6000);
    end
    $display("test deferral and abort done");
    final_report();
  end
endmodule : test_ascr_regs
